// >>> hw/rffe_ctrl_defs.svh
// constants for the serial power and update-strobe register bank
`ifndef RFFE_CTRL_DEFS_SVH
`define RFFE_CTRL_DEFS_SVH
// Operation
// RULE_01 - power-on of the io supply returns every register to its default
// RULE_02 - power state code 01 resets all registers, then enters low power
// RULE_03 - soft reset bit restores defaults except power/strobe control and slave id; the code clears the operating bit of register 0 too
// RULE_04 - code 00 written to register 0 or 28 leaves low power for active
// RULE_05 - code 10 written to register 0 or 28 enters low power from active
// RULE_06 - low power keeps the serial port and registers usable, outputs high impedance
// RULE_07 - in active mode the operating bit turns the boost rail and outputs on
// RULE_08 - after start-up the device is active with the operating bit cleared
// RULE_09 - after entering active mode allow the wake-up interval before output updates
// RULE_10 - a data rise then fall with the serial clock low starts a sequence
// RULE_11 - every frame ends in a parity bit making the count of ones odd
// RULE_12 - a frame with bad parity is discarded and changes no register
// RULE_13 - the party releasing data drives it low for one park cycle
// RULE_14 - register write and register read sequences are accepted
// RULE_15 - extended writes carry byte count, start address, up to four bytes
// RULE_16 - registers 28 to 31 also answer broadcast sequences
// RULE_17 - three update strobes, default map A-C to 0, D-F to 1, remappable
// RULE_18 - unmasked strobes hold writes in shadow registers, outputs unchanged
// RULE_19 - strobe bits written with mask low copy shadow to mapped channels
// RULE_20 - a set mask bit sends channel writes straight to the outputs
// RULE_21 - updates start at park of a strobe write, else at each data parity
// RULE_22 - the power state code field exists in both register 0 and 28
// RULE_23 - sequences for another slave id are ignored and never answered

`define A_PWR          5'h00
`define A_GLIDE_ABC    5'h01
`define A_DAC_A        5'h02
`define A_DAC_C        5'h04
`define A_GLIDE_DEF    5'h05
`define A_DAC_D        5'h06
`define A_DAC_F        5'h08
`define A_CFG_AB       5'h09
`define A_CFG_EF       5'h0b
`define A_SOFT_RST     5'h1a
`define A_PWR_TRIG     5'h1c
`define A_PROD_ID      5'h1d
`define A_MANUF_LO     5'h1e
`define A_USID         5'h1f

`define RST_CFG        24'h440400
`define RST_USID       4'h7
`define PWR_FIXED      3'h2

`define B_ACTIVE       5
`define B_SOFT_RST     7
`define B_MASK_LO      3
`define B_CODE28_LO    6
`define CFG_HI_LSB     6
`define CFG_LO_LSB     2

`define CODE_ACTIVE    2'h0
`define CODE_DEV_RST   2'h1
`define CODE_LOW_PWR   2'h2

`define CMD_WRITE      3'h2
`define CMD_READ       3'h3
`define CMD_EXT        4'h0
`define BCAST_SID      4'h0
`define MAX_BC         4'h3
`define CMD_LAST_BIT   4'hc
`define BYTE_LAST_BIT  4'h8

`define CLK_PERIOD_NS  40
`define WAKE_MAX_US    250
`define WAKE_CYC       ((`WAKE_MAX_US * 1000) / `CLK_PERIOD_NS)
`endif

// >>> hw/rffe_ctrl_pkg.sv
// types shared by the register bank and its serial front end
package rffe_ctrl_pkg;
    typedef enum logic [1:0] {PWR_ACTIVE, PWR_WAKING, PWR_LOW} pwr_e;
    typedef enum logic [2:0] {
        L_IDLE, L_CMD, L_EADDR, L_WDATA, L_WPARK, L_RDBP, L_RDATA, L_RPARK
    } link_e;
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] data;
    } wr_s;
    typedef struct packed {
        logic hv_on;
        logic hiz;
        logic low_power;
    } pwr_out_s;
    typedef logic [31:0][7:0] reg_image_t;
    typedef logic [5:0][7:0]  dac_bank_t;
endpackage

// >>> hw/rffe_power_trigger_control.sv
// serial slave, power states and update-strobe register bank
`timescale 1ns/10ps
`include "rffe_ctrl_defs.svh"
module rffe_power_trigger_control #(
    parameter int unsigned WAKE_CYC   = `WAKE_CYC,
    parameter logic [5:0]  PRODUCT_ID = 6'h15,   // arbitrary value
    parameter logic [9:0]  MANUF_ID   = 10'h2a5  // arbitrary value
) (
    input  wire logic                      clk,
    input  wire logic                      srst,
    input  wire logic                      sclk,
    input  wire logic                      sdata_i,
    input  wire logic [1:0]                sel_id_i,
    output logic                           sdata_o,
    output logic                           sdata_oe,
    output rffe_ctrl_pkg::dac_bank_t       dac_level,
    output logic [5:0]                     dac_load,
    output rffe_ctrl_pkg::pwr_out_s        pwr_out
);
    // ---------------- link domain (sclk) ----------------
    logic                     lrst_s1, lrst_s2;
    rffe_ctrl_pkg::link_e     link_q;
    logic [3:0]               cnt_q;
    logic [12:0]              sh_q;
    logic [12:0]              sh_d;
    logic [7:0]               addr_q;
    logic [3:0]               bc_q;
    logic                     bcast_q;
    logic                     pend_q;
    logic [7:0]               rd_q;
    logic                     rpar_q;
    logic                     take_q;
    logic                     ssc;
    rffe_ctrl_pkg::wr_s       wr_q;
    logic                     wr_tog_q;
    rffe_ctrl_pkg::reg_image_t mirror_q;
    logic                     snap_s1, snap_s2, seen_q;
    // ---------------- core domain (clk) ----------------
    rffe_ctrl_pkg::reg_image_t snap_q;
    rffe_ctrl_pkg::reg_image_t img;
    logic                     snap_req_q, ack_s1, ack_s2;
    logic                     wr_s1, wr_s2, wr_s3;
    logic                     wr_ev;
    logic [1:0]               sid_s1, sid_s2;
    rffe_ctrl_pkg::pwr_e      pwr_q;
    logic [12:0]              wake_q;
    logic [1:0]               code_q;
    logic                     act_q;
    logic [1:0][7:0]          glide_q;
    rffe_ctrl_pkg::dac_bank_t shadow_q;
    logic [2:0][7:0]          cfg_q;
    logic [2:0]               mask_q;
    logic [3:0]               usid_q;
    logic                     code_wr;
    logic [1:0]               code_val;
    logic                     dev_rst;
    logic                     soft_rst;

    // odd parity holds when the xor of all bits, parity included, is one
    function automatic logic par_ok(input logic [12:0] f);
        par_ok = ^f;
    endfunction

    function automatic logic is_dac(input logic [4:0] a);
        is_dac = (a >= `A_DAC_A && a <= `A_DAC_C) || (a >= `A_DAC_D && a <= `A_DAC_F);
    endfunction

    function automatic logic [2:0] dac_chan(input logic [4:0] a);
        dac_chan = (a <= `A_DAC_C) ? 3'(a - `A_DAC_A) : 3'(a - 5'h03);
    endfunction

    // strobe code 3 has no strobe of its own and is served by strobe 2
    function automatic logic [1:0] strobe_of(input logic [2:0][7:0] cfg,
                                             input logic [2:0]      ch);
        logic [1:0] f;
        f = ch[0] ? cfg[ch[2:1]][`CFG_LO_LSB +: 2] : cfg[ch[2:1]][`CFG_HI_LSB +: 2];
        strobe_of = (f == 2'h3) ? 2'h2 : f;
    endfunction

    rffe_ssc_detect u_ssc (
        .sclk    (sclk),
        .sdata_i (sdata_i),
        .clear   (take_q),
        .ssc     (ssc)
    );

    // reset reaches the link side through two flops on its own clock
    always_ff @(posedge sclk) begin
        lrst_s1 <= srst;
        lrst_s2 <= lrst_s1;
    end

    assign sh_d = {sh_q[11:0], sdata_i};

    // one-cycle pulse that re-arms the start catcher after it was taken
    always_ff @(posedge sclk) begin
        take_q <= (link_q == rffe_ctrl_pkg::L_IDLE) && ssc;
    end

    // register image copy arrives by toggle handshake, held stable meanwhile
    always_ff @(posedge sclk) begin
        if (lrst_s2) begin
            snap_s1  <= 1'b0;
            snap_s2  <= 1'b0;
            seen_q   <= 1'b0;
            mirror_q <= '0;
        end else begin
            snap_s1 <= snap_req_q;
            snap_s2 <= snap_s1;
            if (snap_s2 != seen_q) begin
                mirror_q <= snap_q;
                seen_q   <= snap_s2;
            end
        end
    end

    // frame engine: data sampled on the rising clock edge
    always_ff @(posedge sclk) begin
        if (lrst_s2) begin
            link_q   <= rffe_ctrl_pkg::L_IDLE;
            cnt_q    <= 4'h0;
            sh_q     <= 13'h0;
            addr_q   <= 8'h00;
            bc_q     <= 4'h0;
            bcast_q  <= 1'b0;
            pend_q   <= 1'b0;
            rd_q     <= 8'h00;
            rpar_q   <= 1'b0;
            wr_q     <= '0;
            wr_tog_q <= 1'b0;
            sdata_o  <= 1'b0;
            sdata_oe <= 1'b0;
        end else begin
            unique case (link_q)
                rffe_ctrl_pkg::L_IDLE: begin
                    sdata_oe <= 1'b0;
                    if (ssc) begin
                        link_q <= rffe_ctrl_pkg::L_CMD;
                        sh_q   <= {12'h000, sdata_i};
                        cnt_q  <= 4'h1;
                    end
                end
                rffe_ctrl_pkg::L_CMD: begin
                    sh_q  <= sh_d;
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == `CMD_LAST_BIT) begin
                        cnt_q   <= 4'h0;
                        bcast_q <= sh_d[12:9] == `BCAST_SID;
                        addr_q  <= {3'h0, sh_d[5:1]};
                        bc_q    <= 4'h0;
                        link_q  <= rffe_ctrl_pkg::L_IDLE;
                        // RULE_12 bad command
                        // RULE_23 foreign id
                        if (par_ok(sh_d) && (sh_d[12:9] == mirror_q[`A_USID][3:0] ||
                                             sh_d[12:9] == `BCAST_SID)) begin
                            // RULE_14 write/read decode
                            if (sh_d[8:6] == `CMD_WRITE) begin
                                link_q <= rffe_ctrl_pkg::L_WDATA;
                            end else if (sh_d[8:6] == `CMD_READ &&
                                         sh_d[12:9] != `BCAST_SID) begin
                                link_q <= rffe_ctrl_pkg::L_RDBP;
                            // RULE_15 extended write
                            end else if (sh_d[8:5] == `CMD_EXT && sh_d[4:1] <= `MAX_BC) begin
                                bc_q   <= sh_d[4:1];
                                link_q <= rffe_ctrl_pkg::L_EADDR;
                            end
                        end
                    end
                end
                rffe_ctrl_pkg::L_EADDR: begin
                    sh_q  <= sh_d;
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == `BYTE_LAST_BIT) begin
                        cnt_q  <= 4'h0;
                        addr_q <= sh_d[8:1];
                        link_q <= par_ok({4'h0, sh_d[8:0]}) ? rffe_ctrl_pkg::L_WDATA
                                                             : rffe_ctrl_pkg::L_IDLE;
                    end
                end
                rffe_ctrl_pkg::L_WDATA: begin
                    sh_q  <= sh_d;
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == `BYTE_LAST_BIT) begin
                        cnt_q  <= 4'h0;
                        addr_q <= addr_q + 8'h01;
                        bc_q   <= bc_q - 4'h1;
                        link_q <= (bc_q == 4'h0) ? rffe_ctrl_pkg::L_WPARK
                                                 : rffe_ctrl_pkg::L_WDATA;
                        // RULE_12 bad data
                        if (!par_ok({4'h0, sh_d[8:0]})) begin
                            link_q <= rffe_ctrl_pkg::L_IDLE;
                        // RULE_16 broadcast range
                        end else if (addr_q[7:5] == 3'h0 &&
                                     (!bcast_q || addr_q[4:2] == 3'h7)) begin
                            wr_q <= '{addr: addr_q[4:0], data: sh_d[8:1]};
                            // RULE_21 strobe write at park
                            if (addr_q[4:0] == `A_PWR_TRIG && bc_q == 4'h0) begin
                                pend_q <= 1'b1;
                            end else begin
                                wr_tog_q <= ~wr_tog_q;
                            end
                        end
                    end
                end
                rffe_ctrl_pkg::L_WPARK: begin
                    link_q <= rffe_ctrl_pkg::L_IDLE;
                    if (pend_q) begin
                        pend_q   <= 1'b0;
                        wr_tog_q <= ~wr_tog_q;
                    end
                end
                rffe_ctrl_pkg::L_RDBP: begin
                    // master parks here; first data bit goes out on this edge
                    sdata_o  <= mirror_q[addr_q[4:0]][7];
                    sdata_oe <= 1'b1;
                    rd_q     <= {mirror_q[addr_q[4:0]][6:0], 1'b0};
                    // RULE_11 read parity
                    rpar_q   <= ~^mirror_q[addr_q[4:0]];
                    link_q   <= rffe_ctrl_pkg::L_RDATA;
                end
                rffe_ctrl_pkg::L_RDATA: begin
                    cnt_q   <= cnt_q + 4'h1;
                    sdata_o <= rd_q[7];
                    rd_q    <= {rd_q[6:0], 1'b0};
                    if (cnt_q == 4'h7) begin
                        cnt_q   <= 4'h0;
                        sdata_o <= rpar_q;
                        link_q  <= rffe_ctrl_pkg::L_RPARK;
                    end
                end
                rffe_ctrl_pkg::L_RPARK: begin
                    // RULE_13 device park
                    sdata_o <= 1'b0;
                    link_q  <= rffe_ctrl_pkg::L_IDLE;
                end
            endcase
        end
    end

    // ---------------- core domain ----------------
    always_ff @(posedge clk) begin
        wr_s1  <= wr_tog_q;
        wr_s2  <= wr_s1;
        wr_s3  <= wr_s2;
        sid_s1 <= sel_id_i;
        sid_s2 <= sid_s1;
        ack_s1 <= seen_q;
        ack_s2 <= ack_s1;
    end

    // write payload is held on the link side for a whole byte time
    assign wr_ev    = wr_s2 ^ wr_s3;
    // RULE_22 shared code field
    assign code_wr  = wr_ev && (wr_q.addr == `A_PWR || wr_q.addr == `A_PWR_TRIG);
    assign code_val = (wr_q.addr == `A_PWR) ? wr_q.data[1:0]
                                            : wr_q.data[`B_CODE28_LO +: 2];
    assign dev_rst  = code_wr && code_val == `CODE_DEV_RST;
    assign soft_rst = wr_ev && wr_q.addr == `A_SOFT_RST && wr_q.data[`B_SOFT_RST];

    always_comb begin
        img                 = '0;
        img[`A_PWR]         = {2'h0, act_q, `PWR_FIXED, code_q};
        img[`A_GLIDE_ABC]   = glide_q[0];
        img[`A_GLIDE_DEF]   = glide_q[1];
        for (int i = 0; i < 3; i++) begin
            img[`A_DAC_A + 5'(i)] = shadow_q[i];
            img[`A_DAC_D + 5'(i)] = shadow_q[i + 3];
            img[`A_CFG_AB + 5'(i)] = cfg_q[i];
        end
        img[`A_PWR_TRIG]    = {code_q, mask_q, 3'h0};
        img[`A_PROD_ID]     = {sid_s2, PRODUCT_ID};
        img[`A_MANUF_LO]    = MANUF_ID[7:0];
        img[`A_USID]        = {2'h0, MANUF_ID[9:8], usid_q};
    end

    // a new image is published whenever the link side has taken the last
    always_ff @(posedge clk) begin
        if (srst) begin
            snap_req_q <= 1'b0;
            snap_q     <= '0;
        end else if (ack_s2 == snap_req_q) begin
            snap_q     <= img;
            snap_req_q <= ~snap_req_q;
        end
    end

    // power states and wake-up interval
    always_ff @(posedge clk) begin
        // RULE_01 power-on
        // RULE_08 start active, idle
        if (srst) begin
            pwr_q  <= rffe_ctrl_pkg::PWR_ACTIVE;
            wake_q <= 13'h0;
            code_q <= `CODE_ACTIVE;
        end else if (code_wr) begin
            wake_q <= 13'h0;
            // RULE_02 device reset
            if (code_val == `CODE_DEV_RST || code_val == `CODE_LOW_PWR) begin
                // RULE_05 to low power
                pwr_q  <= rffe_ctrl_pkg::PWR_LOW;
                code_q <= `CODE_LOW_PWR;
            end else if (code_val == `CODE_ACTIVE) begin
                code_q <= `CODE_ACTIVE;
                // RULE_04 leave low power
                if (pwr_q == rffe_ctrl_pkg::PWR_LOW) begin
                    pwr_q <= rffe_ctrl_pkg::PWR_WAKING;
                end
            end
        end else if (pwr_q == rffe_ctrl_pkg::PWR_WAKING) begin
            wake_q <= wake_q + 13'h1;
            // RULE_09 wake-up interval
            if (wake_q == 13'(WAKE_CYC - 1)) begin
                pwr_q <= rffe_ctrl_pkg::PWR_ACTIVE;
            end
        end
    end

    // RULE_06 outputs off in low power
    // RULE_07 operating bit
    always_ff @(posedge clk) begin
        if (srst) begin
            pwr_out <= '{hv_on: 1'b0, hiz: 1'b1, low_power: 1'b0};
        end else begin
            pwr_out.hv_on     <= pwr_q == rffe_ctrl_pkg::PWR_ACTIVE && act_q;
            pwr_out.hiz       <= !(pwr_q == rffe_ctrl_pkg::PWR_ACTIVE && act_q);
            pwr_out.low_power <= pwr_q == rffe_ctrl_pkg::PWR_LOW;
        end
    end

    // id and strobe masks survive the soft reset
    always_ff @(posedge clk) begin
        // RULE_03 soft reset keeps these
        if (srst || dev_rst) begin
            mask_q <= 3'h0;
            usid_q <= `RST_USID;
        end else if (wr_ev && wr_q.addr == `A_PWR_TRIG) begin
            mask_q <= wr_q.data[`B_MASK_LO +: 3];
        end else if (wr_ev && wr_q.addr == `A_USID) begin
            usid_q <= wr_q.data[3:0];
        end
    end

    // register bank; only the channel values wait for a strobe
    always_ff @(posedge clk) begin
        dac_load <= 6'h00;
        if (srst || dev_rst || soft_rst) begin
            act_q     <= 1'b0;
            glide_q   <= '0;
            shadow_q  <= '0;
            dac_level <= '0;
            // RULE_17 default strobe map
            cfg_q     <= `RST_CFG;
        end else if (wr_ev) begin
            if (wr_q.addr == `A_PWR) begin
                act_q <= wr_q.data[`B_ACTIVE];
            end
            if (wr_q.addr == `A_GLIDE_ABC) begin
                glide_q[0] <= wr_q.data;
            end
            if (wr_q.addr == `A_GLIDE_DEF) begin
                glide_q[1] <= wr_q.data;
            end
            if (wr_q.addr >= `A_CFG_AB && wr_q.addr <= `A_CFG_EF) begin
                cfg_q[2'(wr_q.addr - `A_CFG_AB)] <= wr_q.data;
            end
            if (is_dac(wr_q.addr)) begin
                // RULE_18 shadow hold
                shadow_q[dac_chan(wr_q.addr)] <= wr_q.data;
                // RULE_20 masked strobe passes through
                if (mask_q[strobe_of(cfg_q, dac_chan(wr_q.addr))]) begin
                    dac_level[dac_chan(wr_q.addr)] <= wr_q.data;
                    dac_load[dac_chan(wr_q.addr)]  <= 1'b1;
                end
            end
            if (wr_q.addr == `A_PWR_TRIG) begin
                for (int i = 0; i < 6; i++) begin
                    // RULE_19 strobe copies shadow
                    if (wr_q.data[strobe_of(cfg_q, 3'(i))] &&
                        !wr_q.data[`B_MASK_LO + strobe_of(cfg_q, 3'(i))]) begin
                        dac_level[i] <= shadow_q[i];
                        dac_load[i]  <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // rffe_power_trigger_control

// >>> hw/rffe_ssc_detect.sv
// sequence start catcher clocked by the data line itself
`timescale 1ns/10ps
module rffe_ssc_detect (
    input  wire logic sclk,
    input  wire logic sdata_i,
    input  wire logic clear,
    output logic      ssc
);
    logic arm_q;

    // RULE_10 start edges
    // a data rise with the clock low arms; any clock high disarms
    always_ff @(posedge sdata_i or posedge sclk) begin
        if (sclk) begin
            arm_q <= 1'b0;
        end else begin
            arm_q <= 1'b1;
        end
    end

    // the following data fall completes the start; cleared once taken
    always_ff @(negedge sdata_i or posedge clear) begin
        if (clear) begin
            ssc <= 1'b0;
        end else begin
            ssc <= arm_q;
        end
    end
endmodule // rffe_ssc_detect

// >>> sim/rffe_master_model.sv
// serial bus master model: link clock, data wire and frame tasks
`timescale 1ns/10ps
module rffe_master_model (
    output logic      sclk,
    output logic      sdata_i,
    input  wire logic sdata_o,
    input  wire logic sdata_oe
);
    logic ck = 1'b0;
    logic m_d = 1'b0;
    logic m_oe = 1'b0;
    assign sclk = ck;
    // released wire falls to the pull-down level
    assign sdata_i = sdata_oe ? sdata_o : (m_oe & m_d);
    task automatic tick(input logic b);
        m_d = b;
        #24 ck = 1'b1;
        #24 ck = 1'b0;
    endtask
    task automatic frame(input logic [11:0] v, input int k, input logic bad);
        for (int i = k - 1; i >= 0; i--) tick(v[i]);
        tick(~^v ^ bad);
    endtask
    task automatic start(input logic [3:0] s, input logic [7:0] c);
        m_oe = 1'b1;
        #10 m_d = 1'b1;
        #10 m_d = 1'b0;
        #10 frame({s, c}, 12, 1'b0);
    endtask
    task automatic park();
        m_d = 1'b0;
        #24 ck = 1'b1;
        m_oe = 1'b0;
        #24 ck = 1'b0;
    endtask
    // read: park, nine bits in, device park
    task automatic rd(input logic [3:0] s, input logic [4:0] a, output logic [8:0] r);
        start(s, {3'b011, a});
        park();
        for (int i = 0; i < 9; i++) begin
            #24 r = {r[7:0], sdata_i};
            ck = 1'b1;
            #24 ck = 1'b0;
        end
        tick(1'b0);
    endtask
endmodule // rffe_master_model

// >>> sim/rffe_power_trigger_control_tb.sv
// self-checking bench for the serial power and update-strobe register bank
`timescale 1ns/10ps
module rffe_power_trigger_control_tb;
    logic            clk = 1'b0;
    logic            srst = 1'b1;
    logic            sclk;
    logic            sdata_i;
    logic            sdata_o;
    logic            sdata_oe;
    logic [5:0][7:0] dac_level;
    logic [5:0]      dac_load;
    logic [2:0]      pwr_out;
    logic [8:0]      r;
    logic [4:0]      ra [5] = '{5'h00, 5'h0a, 5'h0b, 5'h1d, 5'h1f};
    logic [7:0]      re [5] = '{8'h08, 8'h04, 8'h44, 8'h95, 8'h27};
    int              err_count = 0;
    int              samples_checked = 0;
    always #20 clk = ~clk;
    // short wake interval keeps the run brief
    rffe_power_trigger_control #(.WAKE_CYC(20)) u_dut (.clk(clk), .srst(srst), .sclk(sclk),
        .sdata_i(sdata_i), .sel_id_i(2'h2), .sdata_o(sdata_o), .sdata_oe(sdata_oe),
        .dac_level(dac_level), .dac_load(dac_load), .pwr_out(pwr_out));
    rffe_master_model u_bus (.sclk(sclk), .sdata_i(sdata_i), .sdata_o(sdata_o),
        .sdata_oe(sdata_oe));
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        u_bus.rd(4'h7, a, r);
        chk(r, {e, ~^e});
    endtask
    task automatic wr(input logic [3:0] s, input logic [4:0] a, input logic [7:0] d,
                      input logic b);
        u_bus.start(s, {3'b010, a});
        u_bus.frame(d, 8, b);
        u_bus.park();
        repeat (6) @(posedge clk);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        fork
            repeat (4) u_bus.tick(1'b0);
            repeat (4) @(posedge clk);
        join
        @(posedge clk);
        #1 srst = 1'b0;
        repeat (8) u_bus.tick(1'b0);
        foreach (ra[i]) rdc(ra[i], re[i]);
        wr(4'h7, 5'h00, 8'h20, 1'b0);
        chk(pwr_out, 3'h4);
        wr(4'h7, 5'h02, 8'h55, 1'b0);
        wr(4'h7, 5'h1c, 8'h02, 1'b0);
        chk(dac_level[0], 8'h00);
        wr(4'h7, 5'h1c, 8'h01, 1'b0);
        chk(dac_level[0], 8'h55);
        wr(4'h7, 5'h09, 8'h80, 1'b0);
        wr(4'h7, 5'h02, 8'h11, 1'b0);
        wr(4'h7, 5'h1c, 8'h03, 1'b0);
        chk(dac_level[0], 8'h55);
        wr(4'h7, 5'h1c, 8'h04, 1'b0);
        chk(dac_level[0], 8'h11);
        $display("test strobes done");
        wr(4'h7, 5'h1c, 8'h38, 1'b0);
        u_bus.start(4'h7, 8'h02);
        u_bus.frame(8'h06, 8, 1'b0);
        for (int i = 0; i < 3; i++) u_bus.frame(8'h0a + 8'(i), 8, 1'b0);
        u_bus.park();
        repeat (6) @(posedge clk);
        chk(dac_level[5], 8'h0c);
        wr(4'h7, 5'h02, 8'h99, 1'b1);
        chk(dac_level[0], 8'h11);
        u_bus.rd(4'h5, 5'h00, r);
        chk(r, 9'h000);
        $display("test masks and refusals done");
        wr(4'h0, 5'h1c, 8'hb8, 1'b0);
        chk(pwr_out, 3'h3);
        rdc(5'h00, 8'h2a);
        wr(4'h7, 5'h00, 8'h20, 1'b0);
        chk(pwr_out[2], 1'b0);
        for (int i = 0; i < 60 && pwr_out[2] !== 1'b1; i++) @(posedge clk);
        chk(pwr_out, 3'h4);
        wr(4'h7, 5'h1a, 8'h80, 1'b0);
        rdc(5'h09, 8'h00);
        wr(4'h7, 5'h1c, 8'h40, 1'b0);
        chk(pwr_out, 3'h3);
        $display("test power and resets done");
        end_sim();
    end
endmodule // rffe_power_trigger_control_tb

// >>> sim/rffe_ptc_monitor.sv
// port checker for the serial power and update-strobe register bank
`timescale 1ns/10ps
module rffe_ptc_monitor (
    input wire logic                     clk,
    input wire logic                     srst,
    input wire logic                     sclk,
    input wire logic                     sdata_o,
    input wire logic                     sdata_oe,
    input wire rffe_ctrl_pkg::dac_bank_t dac_level,
    input wire logic [5:0]               dac_load,
    input wire rffe_ctrl_pkg::pwr_out_s  pwr_out
);
    a_reset_idle: assert property (@(posedge clk) disable iff (srst)
        $fell(srst) |-> pwr_out == 3'h2 && dac_level == '0) else $error("bad reset state");
    a_hiz_follows: assert property (@(posedge clk) disable iff (srst)
        pwr_out.hiz != pwr_out.hv_on) else $error("hiz not inverse of hv");
    a_lp_outputs_off: assert property (@(posedge clk) disable iff (srst)
        pwr_out.low_power |-> pwr_out.hiz) else $error("driven in low power");
    a_wake_hold: assert property (@(posedge clk) disable iff (srst)
        $fell(pwr_out.low_power) |-> !pwr_out.hv_on [*8]) else $error("hv before wake");
    a_load_pulse: assert property (@(posedge clk) disable iff (srst)
        |dac_load |=> dac_load == '0) else $error("load not one pulse");
    a_read_len: assert property (@(posedge sclk) disable iff (srst)
        $rose(sdata_oe) |-> sdata_oe [*8] ##1 sdata_oe ##1 sdata_oe ##1 !sdata_oe)
        else $error("read drive length wrong");
    a_park_low: assert property (@(posedge sclk) disable iff (srst)
        $fell(sdata_oe) |-> !$past(sdata_o)) else $error("release without park");
    a_drive_gap: assert property (@(posedge sclk) disable iff (srst)
        $fell(sdata_oe) |-> !sdata_oe [*8]) else $error("drive without command");
endmodule // rffe_ptc_monitor

bind rffe_power_trigger_control rffe_ptc_monitor u_mon (.clk(clk), .srst(srst), .sclk(sclk),
    .sdata_o(sdata_o), .sdata_oe(sdata_oe), .dac_level(dac_level), .dac_load(dac_load),
    .pwr_out(pwr_out));
